// ---- src/sbt_pkg.sv ----
// Purpose: shared constants and types of the boundary-scan test port
// Assumes: instruction codes and cell layout are local choices
// Notes: identity fields hold arbitrary neutral values
package sbt_pkg;

  // controller states
  typedef enum logic [3:0] {
    SBT_TLR, SBT_RTI,
    SBT_SEL_DR, SBT_CAP_DR, SBT_SH_DR, SBT_EX1_DR, SBT_PA_DR, SBT_EX2_DR, SBT_UPD_DR,
    SBT_SEL_IR, SBT_CAP_IR, SBT_SH_IR, SBT_EX1_IR, SBT_PA_IR, SBT_EX2_IR, SBT_UPD_IR
  } sbt_state_e;

  // test pins as seen after the pads
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbt_pins_s;

  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_LEN = 109;
  localparam int CELL_QOE = 108;

  typedef logic [IR_W-1:0] sbt_ir_t;

  localparam sbt_ir_t IR_EXTEST = 3'h0;
  localparam sbt_ir_t IR_IDCODE = 3'h1;
  localparam sbt_ir_t IR_SAMPLE_Z = 3'h2;
  localparam sbt_ir_t IR_RSVD_A = 3'h3;
  localparam sbt_ir_t IR_SAMPLE_PRELOAD = 3'h4;
  localparam sbt_ir_t IR_RSVD_B = 3'h5;
  localparam sbt_ir_t IR_RSVD_C = 3'h6;
  localparam sbt_ir_t IR_BYPASS = 3'h7;

  // pattern loaded into the instruction shifter on capture
  localparam sbt_ir_t IR_CAPTURE_PAT = 3'h1;

  // pad pull-ups: tms and tdi float high
  localparam sbt_pins_s PINS_RST = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

  // identification code fields (arbitrary values)
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h0a5c;
  localparam logic [10:0] ID_VENDOR = 11'h2b4;
  localparam logic [ID_W-1:0] ID_CODE = {ID_VERSION, ID_PART, ID_VENDOR, 1'b1};

  localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

endpackage

// ---- src/sbt_sync.sv ----
// Purpose: two-flop synchroniser for signals from outside the clock domain
// Assumes: each bit is an independent level
// Notes: only the second stage may be read
`timescale 1ns/100ps
module sbt_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // sbt_sync

// ---- src/sbt_tap.sv ----
// Purpose: boundary-scan test access port of a burst memory
// Assumes: test clock is oversampled by ref_clk_i, tck at most 20 MHz
// Notes: tdo pad resolved by the bench from tdo_oe_o
`timescale 1ns/100ps
module sbt_tap #(
  parameter int BSR_LEN = sbt_pkg::BSR_LEN,
  parameter int CELL_QOE = sbt_pkg::CELL_QOE
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [BSR_LEN-1:0] pin_ring_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [BSR_LEN-1:0] bsr_out_o,
  output logic extest_o,
  output logic q_oe_o
);
  sbt_pkg::sbt_pins_s pins_raw;
  sbt_pkg::sbt_pins_s pins;
  logic [BSR_LEN-1:0] ring;

  assign pins_raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i};

  sbt_sync #(.W(3), .RST_VAL(sbt_pkg::PINS_RST)) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  sbt_sync #(.W(BSR_LEN), .RST_VAL('0)) u_ring_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pin_ring_i),
    .q_o(ring)
  );

  sbt_pkg::sbt_state_e state_q, state_d, nxt;
  sbt_pkg::sbt_ir_t ir_q, ir_d, ir_sh_q, ir_sh_d;
  logic [sbt_pkg::ID_W-1:0] id_sh_q, id_sh_d;
  logic [BSR_LEN-1:0] bsr_sh_q, bsr_sh_d, upd_q, upd_d;
  logic byp_q, byp_d;
  logic tck_q, tdo_q, tdo_d, tdo_oe_q, tdo_oe_d, extest_q, extest_d, q_oe_q, q_oe_d;
  logic tck_rise, tck_fall, shifting, use_bsr, sel_bit;

  assign tck_rise = pins.tck && !tck_q;
  assign tck_fall = !pins.tck && tck_q;
  assign shifting = (state_q == sbt_pkg::SBT_SH_DR) || (state_q == sbt_pkg::SBT_SH_IR);
  // reserved codes fall back to bypass
  assign use_bsr = (ir_q == sbt_pkg::IR_EXTEST) || (ir_q == sbt_pkg::IR_SAMPLE_PRELOAD) ||
                   (ir_q == sbt_pkg::IR_SAMPLE_Z);

  // controller next state
  always_comb begin
    unique case (state_q)
      sbt_pkg::SBT_TLR: nxt = pins.tms ? sbt_pkg::SBT_TLR : sbt_pkg::SBT_RTI;
      sbt_pkg::SBT_RTI: nxt = pins.tms ? sbt_pkg::SBT_SEL_DR : sbt_pkg::SBT_RTI;
      sbt_pkg::SBT_SEL_DR: nxt = pins.tms ? sbt_pkg::SBT_SEL_IR : sbt_pkg::SBT_CAP_DR;
      sbt_pkg::SBT_CAP_DR: nxt = pins.tms ? sbt_pkg::SBT_EX1_DR : sbt_pkg::SBT_SH_DR;
      sbt_pkg::SBT_SH_DR: nxt = pins.tms ? sbt_pkg::SBT_EX1_DR : sbt_pkg::SBT_SH_DR;
      sbt_pkg::SBT_EX1_DR: nxt = pins.tms ? sbt_pkg::SBT_UPD_DR : sbt_pkg::SBT_PA_DR;
      sbt_pkg::SBT_PA_DR: nxt = pins.tms ? sbt_pkg::SBT_EX2_DR : sbt_pkg::SBT_PA_DR;
      sbt_pkg::SBT_EX2_DR: nxt = pins.tms ? sbt_pkg::SBT_UPD_DR : sbt_pkg::SBT_SH_DR;
      sbt_pkg::SBT_UPD_DR: nxt = pins.tms ? sbt_pkg::SBT_SEL_DR : sbt_pkg::SBT_RTI;
      sbt_pkg::SBT_SEL_IR: nxt = pins.tms ? sbt_pkg::SBT_TLR : sbt_pkg::SBT_CAP_IR;
      sbt_pkg::SBT_CAP_IR: nxt = pins.tms ? sbt_pkg::SBT_EX1_IR : sbt_pkg::SBT_SH_IR;
      sbt_pkg::SBT_SH_IR: nxt = pins.tms ? sbt_pkg::SBT_EX1_IR : sbt_pkg::SBT_SH_IR;
      sbt_pkg::SBT_EX1_IR: nxt = pins.tms ? sbt_pkg::SBT_UPD_IR : sbt_pkg::SBT_PA_IR;
      sbt_pkg::SBT_PA_IR: nxt = pins.tms ? sbt_pkg::SBT_EX2_IR : sbt_pkg::SBT_PA_IR;
      sbt_pkg::SBT_EX2_IR: nxt = pins.tms ? sbt_pkg::SBT_UPD_IR : sbt_pkg::SBT_SH_IR;
      sbt_pkg::SBT_UPD_IR: nxt = pins.tms ? sbt_pkg::SBT_SEL_DR : sbt_pkg::SBT_RTI;
    endcase
  end

  // bit presented on tdo for the selected register
  always_comb begin
    if (state_q == sbt_pkg::SBT_SH_IR) begin
      sel_bit = ir_sh_q[0];
    end else if (use_bsr) begin
      sel_bit = bsr_sh_q[0];
    end else if (ir_q == sbt_pkg::IR_IDCODE) begin
      sel_bit = id_sh_q[0];
    end else begin
      sel_bit = byp_q;
    end
  end

  always_comb begin
    state_d = state_q;
    ir_d = ir_q;
    ir_sh_d = ir_sh_q;
    id_sh_d = id_sh_q;
    bsr_sh_d = bsr_sh_q;
    upd_d = upd_q;
    byp_d = byp_q;
    tdo_d = tdo_q;
    tdo_oe_d = tdo_oe_q;
    if (tck_rise) begin
      state_d = nxt;
      unique case (state_q)
        sbt_pkg::SBT_CAP_IR: ir_sh_d = sbt_pkg::IR_CAPTURE_PAT;
        sbt_pkg::SBT_SH_IR: ir_sh_d = {pins.tdi, ir_sh_q[sbt_pkg::IR_W-1:1]};
        sbt_pkg::SBT_UPD_IR: ir_d = ir_sh_q;
        sbt_pkg::SBT_CAP_DR: begin
          if (use_bsr) begin
            bsr_sh_d = ring;
          end else if (ir_q == sbt_pkg::IR_IDCODE) begin
            id_sh_d = sbt_pkg::ID_CODE;
          end else begin
            byp_d = 1'b0;
          end
        end
        sbt_pkg::SBT_SH_DR: begin
          if (use_bsr) begin
            bsr_sh_d = {pins.tdi, bsr_sh_q[BSR_LEN-1:1]};
          end else if (ir_q == sbt_pkg::IR_IDCODE) begin
            id_sh_d = {pins.tdi, id_sh_q[sbt_pkg::ID_W-1:1]};
          end else begin
            byp_d = pins.tdi;
          end
        end
        sbt_pkg::SBT_UPD_DR: begin
          if ((ir_q == sbt_pkg::IR_EXTEST) || (ir_q == sbt_pkg::IR_SAMPLE_PRELOAD)) begin
            upd_d = bsr_sh_q;
          end
        end
        default: begin
        end
      endcase
      if (nxt == sbt_pkg::SBT_TLR) begin
        ir_d = sbt_pkg::IR_IDCODE;
        upd_d[CELL_QOE] = 1'b1;
      end
    end
    if (tck_fall) begin
      tdo_d = sel_bit;
      tdo_oe_d = shifting;
    end
  end

  // memory-side controls follow the current instruction
  always_comb begin
    extest_d = (ir_q == sbt_pkg::IR_EXTEST);
    if (ir_q == sbt_pkg::IR_SAMPLE_Z) begin
      q_oe_d = 1'b0;
    end else if (ir_q == sbt_pkg::IR_EXTEST) begin
      q_oe_d = upd_q[CELL_QOE];
    end else begin
      q_oe_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= sbt_pkg::SBT_TLR;
      ir_q <= sbt_pkg::IR_IDCODE;
      ir_sh_q <= '0;
      id_sh_q <= '0;
      bsr_sh_q <= '0;
      upd_q <= BSR_LEN'(1) << CELL_QOE;
      byp_q <= 1'b0;
      tck_q <= 1'b0;
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
      extest_q <= 1'b0;
      q_oe_q <= 1'b1;
    end else begin
      state_q <= state_d;
      ir_q <= ir_d;
      ir_sh_q <= ir_sh_d;
      id_sh_q <= id_sh_d;
      bsr_sh_q <= bsr_sh_d;
      upd_q <= upd_d;
      byp_q <= byp_d;
      tck_q <= pins.tck;
      tdo_q <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
      extest_q <= extest_d;
      q_oe_q <= q_oe_d;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
  assign bsr_out_o = upd_q;
  assign extest_o = extest_q;
  assign q_oe_o = q_oe_q;

  // helper: consecutive tms-high rising edges, saturating
  logic [2:0] tms_hi_q, tms_hi_d;
  always_comb begin
    tms_hi_d = tms_hi_q;
    if (tck_rise) begin
      if (!pins.tms) begin
        tms_hi_d = 3'h0;
      end else if (tms_hi_q != sbt_pkg::TMS_RESET_EDGES) begin
        tms_hi_d = tms_hi_q + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tms_hi_q <= 3'h0;
    end else begin
      tms_hi_q <= tms_hi_d;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  tdo_on_fall_a: assert property ($changed(tdo_q) || $changed(tdo_oe_q) |-> $past(tck_fall))
    else $error("tdo changed away from a falling tck edge");
  tdo_enable_a: assert property (tck_fall |=> tdo_oe_q == $past(shifting))
    else $error("tdo enable does not match shift state");
  state_on_rise_a: assert property ($changed(state_q) |-> $past(tck_rise))
    else $error("controller moved without a rising tck edge");
  five_tms_reset_a: assert property (tms_hi_q == sbt_pkg::TMS_RESET_EDGES |-> state_q == sbt_pkg::SBT_TLR)
    else $error("five tms-high edges did not reset the controller");
  reset_idcode_a: assert property (state_q == sbt_pkg::SBT_TLR |-> ir_q == sbt_pkg::IR_IDCODE)
    else $error("instruction is not identification in reset state");
  capture_ir_a: assert property (tck_rise && state_q == sbt_pkg::SBT_CAP_IR |=> ir_sh_q[1:0] == 2'b01)
    else $error("capture-ir pattern wrong");
  ir_update_a: assert property ($changed(ir_q) && state_q != sbt_pkg::SBT_TLR
                                |-> $past(state_q) == sbt_pkg::SBT_UPD_IR)
    else $error("instruction changed outside update-ir");
  bypass_clear_a: assert property (tck_rise && state_q == sbt_pkg::SBT_CAP_DR && ir_q == sbt_pkg::IR_BYPASS
                                   |=> !byp_q)
    else $error("bypass not cleared on capture");
  id_capture_a: assert property (tck_rise && state_q == sbt_pkg::SBT_CAP_DR && ir_q == sbt_pkg::IR_IDCODE
                                 |=> id_sh_q == sbt_pkg::ID_CODE)
    else $error("identification code not captured");
  samplez_hiz_a: assert property (ir_q == sbt_pkg::IR_SAMPLE_Z |=> !q_oe_q)
    else $error("output bus enabled under sample-z");
  extest_cell_a: assert property (ir_q == sbt_pkg::IR_EXTEST |=> q_oe_q == $past(upd_q[CELL_QOE]))
    else $error("read bus enable does not follow control cell");

  shift_dr_c: cover property (tck_rise && state_q == sbt_pkg::SBT_SH_DR);
  update_ir_c: cover property (tck_rise && state_q == sbt_pkg::SBT_UPD_IR);
  // reset entry while another instruction was current
  tms_reset_c: cover property (state_q == sbt_pkg::SBT_TLR && $past(state_q) != sbt_pkg::SBT_TLR &&
                               $past(ir_q) != sbt_pkg::IR_IDCODE);
endmodule // sbt_tap

// ---- test/sbt_tap_test.sv ----
// Purpose: self-checking bench of the boundary-scan test port
// Assumes: tester model drives tck, tms and tdi
// Notes: pin ring held constant during the run
`timescale 1ns/100ps
module sbt_tap_test;
  localparam logic [108:0] RING = {13'h1a5b, 96'h0123_4567_89ab_cdef_fedc_ba98};
  localparam logic [108:0] PRE = {13'h0c3d, 96'hf0e1_d2c3_b4a5_9687_7869_5a4b};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, extest, q_oe;
  logic [108:0] ring = RING;
  logic [108:0] bsr_out;
  int errors = 0;
  int cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  sbt_tap u_sbt_tap (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .pin_ring_i(ring), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .bsr_out_o(bsr_out), .extest_o(extest), .q_oe_o(q_oe));
  sbt_tester_model u_sbt_tester_model (.ref_clk_i(ref_clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic moves(input logic [7:0] seq, input int n);
    logic d, e;
    for (int i = 0; i < n; i++) u_sbt_tester_model.tick(seq[i], 1'b1, d, e);
  endtask
  // n bits through the selected register, then update and idle
  task automatic scan(input logic [127:0] din, input int n, output logic [127:0] dout);
    logic e;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      u_sbt_tester_model.tick(i == n - 1, din[i], dout[i], e);
      chk("tdo_oe", e, 1'b1);
    end
    moves(8'h01, 2);
  endtask
  task automatic load_ir(input logic [2:0] code);
    logic [127:0] o;
    moves(8'h06, 5);
    scan({125'h0, code}, 3, o);
    chk("ir_capture", o[1:0], 2'b01);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_reset();
    chk("tdo_oe", tdo_oe, 1'b0);
    chk("q_oe", q_oe, 1'b1);
    chk("extest", extest, 1'b0);
    chk("cell_qoe", bsr_out[108], 1'b1);
  endtask
  task automatic t_idcode();
    logic [127:0] o;
    logic d, e;
    moves(8'h02, 4);
    scan({96'h0, 32'hc3a5_96e1}, 64, o);
    chk("idcode", o[31:0], sbt_pkg::ID_CODE);
    chk("id_passthru", o[63:32], 32'hc3a5_96e1);
    u_sbt_tester_model.tick(1'b0, 1'b1, d, e);
    chk("tdo_oe_idle", e, 1'b0);
  endtask
  task automatic t_bypass();
    logic [127:0] o;
    logic [2:0] codes [4] = '{sbt_pkg::IR_BYPASS, sbt_pkg::IR_RSVD_A, sbt_pkg::IR_RSVD_B, sbt_pkg::IR_RSVD_C};
    foreach (codes[k]) begin
      load_ir(codes[k]);
      moves(8'h02, 4);
      scan(128'hb5, 9, o);
      chk("bypass", o[8:0], {8'hb5, 1'b0});
      chk("q_oe", q_oe, 1'b1);
    end
  endtask
  task automatic t_boundary();
    logic [127:0] o;
    load_ir(sbt_pkg::IR_SAMPLE_PRELOAD);
    chk("extest", extest, 1'b0);
    moves(8'h02, 4);
    scan({19'h0, PRE}, 109, o);
    chk("bsr_capture", o[108:0], RING);
    chk("bsr_update", bsr_out, PRE);
    load_ir(sbt_pkg::IR_EXTEST);
    chk("extest", extest, 1'b1);
    chk("q_oe", q_oe, PRE[108]);
    load_ir(sbt_pkg::IR_SAMPLE_Z);
    chk("extest", extest, 1'b0);
    chk("q_oe", q_oe, 1'b0);
    moves(8'h1f, 5);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("q_oe", q_oe, 1'b1);
    chk("cell_qoe", bsr_out[108], 1'b1);
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    t_reset();
    t_idcode();
    t_bypass();
    t_boundary();
    t_idcode();
    conclude();
  end
  initial begin
    #400000;
    errors++;
    conclude();
  end
endmodule // sbt_tap_test

// ---- test/sbt_tester_model.sv ----
// Purpose: behavioural board test controller driving the scan port
// Assumes: tck period 125 ns, 25 ref_clk cycles a tick
// Notes: tck stands low between ticks; released tdo shows no stale value
`timescale 1ns/100ps
module sbt_tester_model (
  input wire logic ref_clk_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  logic last_q = 1'b0;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // one tck period; tdo taken just before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
    @(posedge ref_clk_i);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (11) @(negedge ref_clk_i);
    oe = tdo_oe_i;
    tdo = tdo_oe_i ? tdo_i : ~last_q;
    if (tdo_oe_i) last_q = tdo_i;
    @(posedge ref_clk_i);
    tck_o <= 1'b1;
    repeat (13) @(posedge ref_clk_i);
    tck_o <= 1'b0;
  endtask
endmodule // sbt_tester_model
